// file: verilog/opc_pkg.sv
package opc_pkg;

    // ------------------------------------------------------------------
    // Command opcodes seen on the command register write port
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_CMD_NOP        = 8'h00;
    localparam logic [7:0] OPC_CMD_PACKET     = 8'ha0;
    localparam logic [7:0] OPC_CMD_IDENTIFY   = 8'hec;
    localparam logic [7:0] OPC_CMD_DEV_RESET  = 8'h08;
    localparam logic [7:0] OPC_CMD_SERVICE    = 8'ha2;
    localparam logic [7:0] OPC_CMD_RD_QUEUED  = 8'hc7;
    localparam logic [7:0] OPC_CMD_RD_QUEUEDX = 8'h26;
    localparam logic [7:0] OPC_CMD_WR_QUEUED  = 8'hcc;
    localparam logic [7:0] OPC_CMD_WR_QUEUEDX = 8'h36;

    // ------------------------------------------------------------------
    // Subcommand and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_NOP_AUTO_POLL  = 8'h01;
    localparam logic [7:0] OPC_NOP_PLAIN      = 8'h00;
    localparam int         OPC_OVL_POS        = 0;

    // ------------------------------------------------------------------
    // Packet-device signature left in the count, sector and cylinder registers
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_SIG_CYL_LOW    = 8'h14;
    localparam logic [7:0] OPC_SIG_CYL_HIGH   = 8'heb;
    localparam logic [7:0] OPC_SIG_COUNT      = 8'h01;
    localparam logic [7:0] OPC_SIG_SECTOR     = 8'h01;

    // ------------------------------------------------------------------
    // Sizes, timing counts and abort error code
    // ------------------------------------------------------------------
    localparam int         OPC_PKT_WORDS      = 6;
    localparam logic [2:0] OPC_PKT_LAST       = 3'(OPC_PKT_WORDS - 1);
    localparam logic [3:0] OPC_PREP_CYCLES    = 4'h4;
    localparam logic [7:0] OPC_ERR_ABORT      = 8'h04;

    // Status byte carried to the host side.
    typedef struct packed {
        logic busy_flag_bit;
        logic ready_bit;
        logic fault_bit;
        logic service_request_bit;
        logic data_request_bit;
        logic corr_bit;
        logic index_bit;
        logic error_bit;
    } opc_status_type;

    // Signature register image.
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] sector;
        logic [7:0] cyl_low;
        logic [7:0] cyl_high;
    } opc_sig_type;

endpackage

// file: verilog/opc_ctl.sv
`timescale 1ns/10ps
// Overview of operation
// - Packet accepted: busy, then data request
// - Last packet word: busy set, request cleared
// - Hardware and soft reset load packet signature
// - Identify command aborted, signature loaded
// - Device reset command not decoded as a reset
// - Bus release clears busy and request
// - Only listed commands may overlap
// - Overlap bit sampled at command write
// - Overlap with release interrupt releases bus
// - Ready released command: service, gated interrupt
// - Release interrupt off: finish or release
// - Queued DMA: finish or release
// - Service shown whether or not selected
// - Auto poll: error only, queue kept
// - Status read or command write clears pending
module opc_ctl
    import opc_pkg::*;
(
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           rst,
    // Resets from the host side
    input  wire logic           soft_reset,
    // Task-file access
    input  wire logic           cmd_write,
    input  wire logic [7:0]     cmd_code,
    input  wire logic [7:0]     features,
    input  wire logic           status_read,
    input  wire logic           data_write,
    input  wire logic           dev_selected,
    input  wire logic           interrupt_disable_bit,
    // Configuration and back end
    input  wire logic           release_int_enable,
    input  wire logic           overlap_supported,
    input  wire logic           exec_ready,
    input  wire logic           exec_done,
    // Outputs to the host side
    output opc_status_type      status,
    output opc_sig_type         signature,
    output logic [7:0]          error_reg,
    output logic                host_interrupt_line,
    output logic [7:0]          released_count
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum {ST_IDLE, ST_PREP, ST_PKT, ST_EXEC, ST_DONE} opc_state_type;
    opc_state_type state_reg;
    logic [3:0]    prep_reg;
    logic [2:0]    word_reg;
    logic          ovl_reg;
    logic          pending_reg;
    logic          wants_release;
    logic          ovl_ok;
    logic          any_reset;
    logic          svc_event;

    assign any_reset = rst | soft_reset;
    assign ovl_ok = (cmd_code == OPC_CMD_PACKET) || (cmd_code == OPC_CMD_RD_QUEUED)
                  || (cmd_code == OPC_CMD_RD_QUEUEDX) || (cmd_code == OPC_CMD_WR_QUEUED)
                  || (cmd_code == OPC_CMD_WR_QUEUEDX) || (cmd_code == OPC_CMD_SERVICE);
    // release on overlap with release interrupt; release if not ready
    assign wants_release = ovl_reg && (release_int_enable || !exec_ready);
    // A released command becomes ready for service when the back end says so.
    assign svc_event = exec_ready && (released_count != 8'h00) && (state_reg == ST_IDLE);

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    // Hardware and soft resets share this path; the other drive never sees them.
    always_ff @(posedge ref_clk)
    begin
        if (any_reset)
        begin
            state_reg <= ST_IDLE;
            prep_reg  <= 4'h0;
            word_reg  <= 3'h0;
            ovl_reg   <= 1'b0;
        end
        else if (cmd_write && (state_reg == ST_IDLE))
        begin
            ovl_reg <= features[OPC_OVL_POS] & overlap_supported;
            if (cmd_code == OPC_CMD_PACKET)
            begin
                state_reg <= ST_PREP;
                prep_reg  <= OPC_PREP_CYCLES;
            end
            else if (ovl_ok)
            begin
                state_reg <= ST_EXEC;
            end
        end
        else
        begin
            case (state_reg)
                ST_PREP:
                begin
                    prep_reg <= prep_reg - 4'h1;
                    if (prep_reg == 4'h1)
                    begin
                        state_reg <= ST_PKT;
                        word_reg  <= 3'h0;
                    end
                end
                ST_PKT:
                begin
                    if (data_write)
                    begin
                        word_reg <= word_reg + 3'h1;
                        if (word_reg == OPC_PKT_LAST)
                        begin
                            state_reg <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC:
                begin
                    if (wants_release || exec_done)
                    begin
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Released command count
    // ------------------------------------------------------------------
    // service held until every released command is served
    always_ff @(posedge ref_clk)
    begin
        if (any_reset)
        begin
            released_count <= 8'h00;
        end
        else
        begin
            if ((state_reg == ST_EXEC) && wants_release && !exec_done
                && !(cmd_write && cmd_code == OPC_CMD_SERVICE))
            begin
                released_count <= released_count + 8'h01;
            end
            else if (cmd_write && (state_reg == ST_IDLE) && (cmd_code == OPC_CMD_SERVICE)
                     && (released_count != 8'h00))
            begin
                released_count <= released_count - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status, error and signature
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (any_reset)
        begin
            status    <= '0;
            error_reg <= 8'h00;
            signature <= {OPC_SIG_COUNT, OPC_SIG_SECTOR, OPC_SIG_CYL_LOW, OPC_SIG_CYL_HIGH};
        end
        else
        begin
            status.busy_flag_bit    <= (state_reg == ST_PREP && prep_reg != 4'h1)
                                       || (state_reg == ST_EXEC)
                                       || (state_reg == ST_PKT && data_write
                                           && word_reg == OPC_PKT_LAST);
            status.data_request_bit <= (state_reg == ST_PREP && prep_reg == 4'h1)
                                       || (state_reg == ST_PKT
                                           && !(data_write && word_reg == OPC_PKT_LAST));
            status.ready_bit        <= 1'b1;
            status.service_request_bit <= (released_count != 8'h00)
                                          && (exec_ready || status.service_request_bit);
            if (cmd_write && (state_reg == ST_IDLE))
            begin
                if (cmd_code == OPC_CMD_IDENTIFY)
                begin
                    status.error_bit <= 1'b1;
                    error_reg        <= OPC_ERR_ABORT;
                    signature <= {OPC_SIG_COUNT, OPC_SIG_SECTOR,
                                  OPC_SIG_CYL_LOW, OPC_SIG_CYL_HIGH};
                end
                else if (cmd_code == OPC_CMD_NOP)
                begin
                    // auto poll only flags an error, queue untouched
                    status.error_bit <= 1'b1;
                    error_reg        <= OPC_ERR_ABORT;
                end
                else
                begin
                    status.error_bit <= 1'b0;
                    error_reg        <= 8'h00;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pending and line
    // ------------------------------------------------------------------
    // A service event in the clearing cycle wins so the request is not lost.
    always_ff @(posedge ref_clk)
    begin
        if (any_reset)
        begin
            pending_reg <= 1'b0;
        end
        else if (svc_event && !status.service_request_bit)
        begin
            pending_reg <= 1'b1;
        end
        // status read or command write clears
        else if (status_read || cmd_write)
        begin
            pending_reg <= 1'b0;
        end
    end

    // line gated by selection and disable bit
    always_ff @(posedge ref_clk)
    begin
        if (any_reset)
        begin
            host_interrupt_line <= 1'b0;
        end
        else
        begin
            host_interrupt_line <= pending_reg && dev_selected && !interrupt_disable_bit;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // busy before data request
    a_packet_busy_first: assert property (@(posedge ref_clk) disable iff (any_reset)
        (cmd_write && cmd_code == OPC_CMD_PACKET && state_reg == ST_IDLE)
        |=> ##1 status.busy_flag_bit && !status.data_request_bit)
        else $error("busy not shown after packet command");
    a_flags_exclusive: assert property (@(posedge ref_clk) disable iff (any_reset)
        !(status.busy_flag_bit && status.data_request_bit))
        else $error("busy and data request both set");
    a_last_word_busy: assert property (@(posedge ref_clk) disable iff (any_reset)
        (state_reg == ST_PKT && data_write && word_reg == OPC_PKT_LAST)
        |=> status.busy_flag_bit && !status.data_request_bit)
        else $error("flags wrong after last packet word");
    a_pending_clear: assert property (@(posedge ref_clk) disable iff (any_reset)
        (status_read && !svc_event) |=> !pending_reg)
        else $error("pending survived status read");
    a_intr_gated: assert property (@(posedge ref_clk) disable iff (any_reset)
        host_interrupt_line |-> $past(dev_selected) && !$past(interrupt_disable_bit))
        else $error("interrupt raised while gated");
    a_identify_abort: assert property (@(posedge ref_clk) disable iff (any_reset)
        (cmd_write && cmd_code == OPC_CMD_IDENTIFY && state_reg == ST_IDLE)
        |=> status.error_bit && error_reg == OPC_ERR_ABORT)
        else $error("identify not aborted");
    a_poll_keeps_queue: assert property (@(posedge ref_clk) disable iff (any_reset)
        (cmd_write && cmd_code == OPC_CMD_NOP && state_reg == ST_IDLE)
        |=> status.error_bit && released_count >= $past(released_count))
        else $error("auto poll disturbed the queue");
    a_reset_signature: assert property (@(posedge ref_clk)
        $past(rst) |-> signature.cyl_high == OPC_SIG_CYL_HIGH)
        else $error("signature missing after reset");
    a_release_clears: assert property (@(posedge ref_clk) disable iff (any_reset)
        (state_reg == ST_EXEC && wants_release && !cmd_write) |=> ##1
        !status.busy_flag_bit && !status.data_request_bit)
        else $error("bus not released");

endmodule // opc_ctl

// file: testbench/opc_host_model.sv
`timescale 1ns/10ps
// Host adapter model driving the task-file strobes of one device.
module opc_host_model
    import opc_pkg::*;
(
    // Clock and device status
    input  wire logic     ref_clk,
    input  opc_status_type status,
    // Task-file strobes and levels
    output logic          cmd_write,
    output logic [7:0]    cmd_code,
    output logic [7:0]    features,
    output logic          status_read,
    output logic          data_write,
    output logic          dev_selected,
    output logic          interrupt_disable_bit
);
    // Idle host: selected, interrupts allowed, no strobes.
    initial
    begin
        cmd_write = 1'b0;
        cmd_code = 8'h5a;
        features = 8'ha5;
        status_read = 1'b0;
        data_write = 1'b0;
        dev_selected = 1'b1;
        interrupt_disable_bit = 1'b0;
    end

    task automatic command(input logic [7:0] code, input logic [7:0] feat);
        @(posedge ref_clk);
        cmd_code <= code;
        features <= feat;
        cmd_write <= 1'b1;
        @(posedge ref_clk);
        cmd_write <= 1'b0;
        cmd_code <= ~code; // Stale bus must not look valid.
        features <= ~feat;
    endtask

    task automatic words(input int n, input int gap);
        repeat (n)
        begin
            repeat (gap) @(posedge ref_clk);
            @(posedge ref_clk);
            data_write <= 1'b1;
            @(posedge ref_clk);
            data_write <= 1'b0;
        end
    endtask

    // Status read pulse.
    task automatic poll();
        @(posedge ref_clk);
        status_read <= 1'b1;
        @(posedge ref_clk);
        status_read <= 1'b0;
    endtask

    task automatic select(input logic sel, input logic dis);
        @(posedge ref_clk);
        interrupt_disable_bit <= 1'b1;
        @(posedge ref_clk);
        dev_selected <= sel;
        @(posedge ref_clk);
        interrupt_disable_bit <= dis;
    endtask

    // This adapter has no hardware poll, so the device answers the probe.
    // probe not intercepted
    task automatic auto_poll(output logic err);
        command(OPC_CMD_NOP, OPC_NOP_AUTO_POLL);
        repeat (3) @(posedge ref_clk);
        #1 err = status.error_bit;
    endtask
endmodule // opc_host_model

// file: testbench/tb_opc_ctl.sv
`timescale 1ns/10ps
module tb_opc_ctl
    import opc_pkg::*;
;
    logic           ref_clk, rst, soft_reset, exec_ready, exec_done, overlap_request_bit, err;
    logic           release_int_enable, overlap_supported, host_interrupt_line;
    logic           cmd_write, status_read, data_write, dev_selected, interrupt_disable_bit;
    logic [7:0]     cmd_code, features, error_reg, released_count;
    opc_status_type status;
    opc_sig_type    signature;
    logic [3:0]     flags;
    logic [3:0]     cases [5] = '{4'b1011, 4'b1111, 4'b1101, 4'b1100, 4'b0110};
    int             fail_count, num_checks;

    // Flags polled by the bounded waits.
    assign flags = {host_interrupt_line, status.service_request_bit,
                    status.data_request_bit, status.busy_flag_bit};

    opc_ctl opc_ctl_i (.ref_clk(ref_clk), .rst(rst), .soft_reset(soft_reset),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .features(features),
        .status_read(status_read), .data_write(data_write), .dev_selected(dev_selected),
        .interrupt_disable_bit(interrupt_disable_bit), .release_int_enable(release_int_enable),
        .overlap_supported(overlap_supported), .exec_ready(exec_ready), .exec_done(exec_done),
        .status(status), .signature(signature), .error_reg(error_reg),
        .host_interrupt_line(host_interrupt_line), .released_count(released_count));

    opc_host_model opc_host_model_i (.ref_clk(ref_clk), .status(status),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .features(features),
        .status_read(status_read), .data_write(data_write), .dev_selected(dev_selected),
        .interrupt_disable_bit(interrupt_disable_bit));

    // Free-running 20 MHz clock.
    always #25 ref_clk = ~ref_clk;

    // Release expected from {supported, overlap bit, release irq, back end ready}.
    function automatic logic exp_release(input logic [3:0] c);
        return c[3] & c[2] & (c[1] | !c[0]);
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait; a timeout shows up in the following compare.
    task automatic wait_for(input int idx, input logic val);
        int n;
        n = 0;
        @(posedge ref_clk);
        #1;
        while (flags[idx] !== val && n < 40)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    task automatic packet(input logic [7:0] feat);
        opc_host_model_i.command(OPC_CMD_PACKET, feat);
        wait_for(0, 1'b1);
        check("drq while busy", 0, status.data_request_bit);
        wait_for(1, 1'b1);
        check("busy at drq", 0, status.busy_flag_bit);
        opc_host_model_i.words(OPC_PKT_WORDS, $urandom_range(2));
        #1;
        if (status.data_request_bit === 1'b1)
        begin
            @(posedge ref_clk);
            #1;
        end
        check("busy drq after packet", 2'b01, flags[1:0]);
    endtask

    task automatic finish_cmd();
        @(posedge ref_clk);
        exec_done <= 1'b1;
        @(posedge ref_clk);
        exec_done <= 1'b0;
        wait_for(0, 1'b0);
        check("busy after done", 0, status.busy_flag_bit);
    endtask

    task automatic serve(input logic [7:0] left);
        opc_host_model_i.poll();
        opc_host_model_i.command(OPC_CMD_SERVICE, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        check("count after service", left, released_count);
        check("service bit", left != 0, status.service_request_bit);
        finish_cmd();
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog sized well beyond the whole sequence.
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        $display("Error watchdog expected finish seen hang");
        results();
    end

    initial
    begin
        void'($urandom(32'hcc391f57));
        {ref_clk, rst, soft_reset, exec_ready, exec_done} = 5'b01000;
        {release_int_enable, overlap_supported} = 2'b11;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("signature", {OPC_SIG_COUNT, OPC_SIG_SECTOR, OPC_SIG_CYL_LOW, OPC_SIG_CYL_HIGH},
              signature);
        check("reset flags", 0, {released_count, flags});
        $display("test reset done");
        // Five overlap conditions, released or completed in place.
        foreach (cases[k])
        begin
            @(posedge ref_clk);
            {overlap_supported, release_int_enable, exec_ready} <= {cases[k][3], cases[k][1:0]};
            overlap_request_bit = cases[k][2];
            packet({7'($urandom), overlap_request_bit});
            wait_for(0, 1'b0);
            check("released", exp_release(cases[k]), released_count);
            check("busy drq", exp_release(cases[k]) ? 0 : 1, flags[1:0]);
            if (exp_release(cases[k]))
            begin
                @(posedge ref_clk);
                exec_ready <= 1'b1;
                wait_for(3, 1'b1);
                check("service and irq", 2'b11, flags[3:2]);
                @(posedge ref_clk);
                exec_ready <= 1'b0;
                opc_host_model_i.poll();
                wait_for(3, 1'b0);
                check("irq cleared", 0, host_interrupt_line);
                serve(0);
            end
            else
                finish_cmd();
        end
        $display("test overlap table done");
        // Deselected, then disabled: no interrupt line.
        for (int k = 0; k < 2; k++)
        begin
            @(posedge ref_clk);
            {release_int_enable, overlap_supported, exec_ready} <= 3'b110;
            packet(8'h01);
            wait_for(0, 1'b0);
            opc_host_model_i.select(k[0], k[0]);
            @(posedge ref_clk);
            exec_ready <= 1'b1;
            repeat (6) @(posedge ref_clk);
            #1;
            check("gated irq", 0, host_interrupt_line);
            @(posedge ref_clk);
            exec_ready <= 1'b0;
            opc_host_model_i.select(1'b1, 1'b0);
            serve(0);
        end
        $display("test gating done");
        packet({7'($urandom), 1'b1});
        wait_for(0, 1'b0);
        packet({7'($urandom), 1'b1});
        wait_for(0, 1'b0);
        opc_host_model_i.auto_poll(err);
        check("poll error", 1, err);
        check("queue kept", 2, released_count);
        @(posedge ref_clk);
        exec_ready <= 1'b1;
        wait_for(2, 1'b1);
        @(posedge ref_clk);
        exec_ready <= 1'b0;
        serve(1);
        // queued write released when not ready
        opc_host_model_i.command(OPC_CMD_WR_QUEUED, 8'h01);
        wait_for(0, 1'b0);
        check("queued release", 2, released_count);
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("soft signature", {OPC_SIG_COUNT, OPC_SIG_SECTOR, OPC_SIG_CYL_LOW,
              OPC_SIG_CYL_HIGH}, signature);
        check("soft count", 0, released_count);
        opc_host_model_i.command(OPC_CMD_IDENTIFY, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1;
        check("abort code", {OPC_ERR_ABORT, 7'h20, 1'b1}, {error_reg, status});
        check("identify signature", {OPC_SIG_COUNT, OPC_SIG_SECTOR, OPC_SIG_CYL_LOW,
              OPC_SIG_CYL_HIGH}, signature);
        $display("test queue and reset done");
        results();
    end
endmodule // tb_opc_ctl
